// [logic/pldc_pkg.sv]
/*
  constants and types for the decode array and general array output cells.
  assumes a single 100 MHz clock and static configuration inputs.
*/
`default_nettype none
package pldc_pkg;
  // ==========================================================
  // sizes
  localparam int N_IN   = 69;
  localparam int N_DPT  = 43;
  localparam int N_GPT  = 120;
  localparam int N_CELL = 16;
  // ==========================================================
  // shared input bus positions
  localparam int BUS_ADDR = 0;
  localparam int BUS_CTL  = 16;
  localparam int BUS_RST  = 20;
  localparam int BUS_PDN  = 21;
  localparam int BUS_PA   = 22;
  localparam int BUS_PB   = 30;
  localparam int BUS_PC   = 38;
  localparam int BUS_PD   = 42;
  localparam int BUS_PAGE = 44;
  localparam int BUS_FB   = 52;
  localparam int BUS_RDY  = 68;
  // ==========================================================
  // decode array term layout
  localparam int DPT_MAIN   = 0;
  localparam int DPT_SEC    = 24;
  localparam int DPT_SRAM   = 36;
  localparam int DPT_REGW   = 38;
  localparam int DPT_EXT    = 39;
  localparam int DPT_PSEL   = 41;
  localparam int MAIN_TERMS = 3;
  localparam int SEC_TERMS  = 3;
  localparam int SRAM_TERMS = 2;
  // ==========================================================
  // general array term layout and borrowing limits
  localparam int GPT_BC       = 24;
  localparam int GPT_CLK      = 56;
  localparam int GPT_PR       = 72;
  localparam int GPT_CLR      = 88;
  localparam int GPT_AUX      = 104;
  localparam int NAT_AB       = 3;
  localparam int NAT_BC       = 4;
  localparam int BORROW_AB    = 6;
  localparam int BORROW_BC_LO = 5;
  localparam int BORROW_BC_HI = 6;
  localparam logic [7:0] PORTC_PINS = 8'h9c;
  // ==========================================================
  // timing and reset values
  localparam int CLK_PERIOD_NS = 10;
  localparam int EXP_DELAY_NS  = 15;
  localparam int EXP_CYC = (EXP_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
                           EXP_DELAY_NS / CLK_PERIOD_NS;
  localparam logic       CELL_RST = 1'b0;
  localparam logic [7:0] PIN_RST  = 8'h00;
  localparam logic [7:0] OEN_RST  = 8'hff;
  // ==========================================================
  // modes
  typedef enum logic [1:0] {
    PLDC_FF_D  = 2'h0,
    PLDC_FF_T  = 2'h1,
    PLDC_FF_JK = 2'h2,
    PLDC_FF_SR = 2'h3
  } pldc_ff_e;
  typedef enum logic [1:0] {
    PLDC_RT_BURIED = 2'h0,
    PLDC_RT_FIRST  = 2'h1,
    PLDC_RT_SECOND = 2'h2
  } pldc_route_e;
endpackage
`default_nettype wire

// [logic/pldc_top.sv]
/*
  decode array selects and general array output cells with allocator.
  assumes static configuration inputs and inputs synchronous to mclk_i.
*/
// Contract
// - eight main flash selects, each OR of up to three terms.
// - four secondary flash selects, each OR of up to three terms.
// - one sram select, OR of up to two terms.
// - one single-term select for the 256-register control window.
// - two single-term external selects; small package has only one.
// - two single-term peripheral selects enable the data bus repeater.
// - term is AND of chosen inputs; outputs OR their terms.
// - sixteen output cells, twenty input cells, up to 137 terms; general array here has 120.
// - each cell has an xor stage choosing polarity.
// - output mux picks flip-flop or combinational bypass.
// - cell output drives pin, read data and feedback together.
// - flip-flop acts as D, T, JK or SR.
// - clock, preset and clear each come from own term.
// - preset and clear level high; data taken on rising clock.
// - common clock pin may replace a cell's term clock.
// - each cell routes to at most one pin; port A large package only.
// - group one cells own three terms, borrow up to six.
// - group two cells 0-3 own four terms, borrow up to five.
// - group two cells 4-7 own four terms, borrow up to six.
// - borrow only unused neighbour terms, with no added delay.
// - expansion through fed-back cell adds about 15ns to a select; here EXP_CYC is one 10ns cycle.
// - processor load overrides preset, clear and clock.
// - set mask bit blocks processor load of that cell.
`default_nettype none
module pldc_top (
  input  wire logic                       mclk_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  input  wire logic [15:0]                addr_i,
  input  wire logic [3:0]                 bus_ctl_i,
  input  wire logic                       mcu_reset_i,
  input  wire logic                       power_down_i,
  input  wire logic [7:0]                 in_pa_i,
  input  wire logic [7:0]                 in_pb_i,
  input  wire logic [3:0]                 in_pc_i,
  input  wire logic [1:0]                 in_pd_i,
  input  wire logic [7:0]                 page_i,
  input  wire logic                       flash_ready_i,
  input  wire logic                       large_pkg_i,
  input  wire logic                       load_ab_i,
  input  wire logic                       load_bc_i,
  input  wire logic [7:0]                 load_data_i,
  input  wire logic [7:0]                 mask_ab_i,
  input  wire logic [7:0]                 mask_bc_i,
  input  wire logic [42:0][68:0]          dec_true_i,
  input  wire logic [42:0][68:0]          dec_comp_i,
  input  wire logic [8:0]                 dec_exp_en_i,
  input  wire logic [8:0][3:0]            dec_exp_cell_i,
  input  wire logic [119:0][68:0]         gen_true_i,
  input  wire logic [119:0][68:0]         gen_comp_i,
  input  wire logic [15:0][3:0]           cell_keep_i,
  input  wire logic [15:0][7:0]           cell_borrow_i,
  input  wire logic [15:0]                cell_invert_i,
  input  wire logic [15:0]                cell_comb_i,
  input  wire logic [15:0]                cell_common_clk_i,
  input  wire pldc_pkg::pldc_ff_e [15:0]    cell_type_i,
  input  wire pldc_pkg::pldc_route_e [15:0] cell_route_i,
  output logic [7:0]                      main_flash_sector_selects_o,
  output logic [3:0]                      secondary_flash_sector_selects_o,
  output logic                            sram_select_o,
  output logic                            reg_window_select_o,
  output logic [1:0]                      ext_cs_o,
  output logic                            peripheral_port_select_lo_o,
  output logic                            peripheral_port_select_hi_o,
  output logic [7:0]                      port_a_o,
  output logic [7:0]                      port_a_oe_n_o,
  output logic [7:0]                      port_b_o,
  output logic [7:0]                      port_b_oe_n_o,
  output logic [7:0]                      port_c_o,
  output logic [7:0]                      port_c_oe_n_o,
  output logic [7:0]                      read_ab_o,
  output logic [7:0]                      read_bc_o
);
  import pldc_pkg::*;

  // ==========================================================
  // functions
  function automatic logic pt_eval(input logic [68:0] mt,
                                   input logic [68:0] mc,
                                   input logic [68:0] bus);
    return (|(mt | mc)) & (&(~mt | bus)) & (&(~mc | ~bus));
  endfunction

  function automatic int nat_cnt(input int c);
    return (c < 8) ? NAT_AB : NAT_BC;
  endfunction

  function automatic int nat_base(input int c);
    return (c < 8) ? c * NAT_AB : GPT_BC + (c - 8) * NAT_BC;
  endfunction

  function automatic int bor_max(input int c);
    return (c < 8) ? BORROW_AB : (c < 12) ? BORROW_BC_LO : BORROW_BC_HI;
  endfunction

  function automatic int nbr(input int c, input int step);
    return (c & 8) | ((c + step) & 7);
  endfunction

  // ==========================================================
  // state
  logic [15:0]     ff_r;
  logic [15:0]     ff_nxt;
  logic [15:0]     clk_prev_r;
  logic [15:0]     clk_prev_nxt;
  logic [15:0]     fb_r;
  logic [15:0]     fb_nxt;
  logic [8:0]      exp_r [EXP_CYC];
  logic [8:0]      exp_nxt [EXP_CYC];
  logic [7:0]      mfs_nxt;
  logic [3:0]      sfs_nxt;
  logic            sram_nxt;
  logic            regw_nxt;
  logic [1:0]      ecs_nxt;
  logic            psl_nxt;
  logic            psh_nxt;
  logic [7:0]      pa_nxt;
  logic [7:0]      pa_oen_nxt;
  logic [7:0]      pb_nxt;
  logic [7:0]      pb_oen_nxt;
  logic [7:0]      pc_nxt;
  logic [7:0]      pc_oen_nxt;
  logic [68:0]     bus;
  logic [42:0]     dpt;
  logic [119:0]    gpt;
  logic [15:0]     sum;
  logic [15:0]     cell_out;
  logic [7:0]      rab_nxt;
  logic [7:0]      rbc_nxt;

  // ==========================================================
  // shared input bus, feedback from registered cell outputs
  always_comb begin
    bus[BUS_ADDR +: 16] = addr_i;
    bus[BUS_CTL +: 4]   = bus_ctl_i;
    bus[BUS_RST]        = mcu_reset_i;
    bus[BUS_PDN]        = power_down_i;
    bus[BUS_PA +: 8]    = in_pa_i;
    bus[BUS_PB +: 8]    = in_pb_i;
    bus[BUS_PC +: 4]    = in_pc_i;
    bus[BUS_PD +: 2]    = in_pd_i;
    bus[BUS_PAGE +: 8]  = page_i;
    bus[BUS_FB +: 16]   = fb_r;
    bus[BUS_RDY]        = flash_ready_i;
    for (int i = 0; i < N_DPT; i++) begin
      dpt[i] = pt_eval(dec_true_i[i], dec_comp_i[i], bus);
    end
    for (int i = 0; i < N_GPT; i++) begin
      gpt[i] = pt_eval(gen_true_i[i], gen_comp_i[i], bus);
    end
  end

  // ==========================================================
  // decode array
  always_comb begin
    exp_nxt[0] = 9'h000;
    for (int k = 1; k < EXP_CYC; k++) begin
      exp_nxt[k] = exp_r[k - 1];
    end
    for (int s = 0; s < 9; s++) begin
      exp_nxt[0][s] = dec_exp_en_i[s] & cell_out[dec_exp_cell_i[s]];
    end
    for (int s = 0; s < 8; s++) begin
      mfs_nxt[s] = exp_r[EXP_CYC - 1][s];
      for (int t = 0; t < MAIN_TERMS; t++) begin
        mfs_nxt[s] = mfs_nxt[s] | dpt[DPT_MAIN + s * MAIN_TERMS + t];
      end
    end
    for (int s = 0; s < 4; s++) begin
      sfs_nxt[s] = 1'b0;
      for (int t = 0; t < SEC_TERMS; t++) begin
        sfs_nxt[s] = sfs_nxt[s] | dpt[DPT_SEC + s * SEC_TERMS + t];
      end
    end
    sram_nxt = exp_r[EXP_CYC - 1][8];
    for (int t = 0; t < SRAM_TERMS; t++) begin
      sram_nxt = sram_nxt | dpt[DPT_SRAM + t];
    end
    regw_nxt = dpt[DPT_REGW];
    ecs_nxt = {dpt[DPT_EXT + 1] & large_pkg_i, dpt[DPT_EXT]};
    psl_nxt = dpt[DPT_PSEL] & large_pkg_i;
    psh_nxt = dpt[DPT_PSEL + 1] & large_pkg_i;
  end

  // ==========================================================
  // term allocation and polarity
  always_comb begin
    for (int c = 0; c < N_CELL; c++) begin
      sum[c] = 1'b0;
      for (int k = 0; k < nat_cnt(c); k++) begin
        if (cell_keep_i[c][k]) begin
          sum[c] = sum[c] | gpt[nat_base(c) + k];
        end
      end
      for (int k = 0; k < 8; k++) begin
        int d;
        int t;
        logic ok;
        d = (k < 4) ? nbr(c, 1) : nbr(c, 7);
        t = (k < 4) ? k : k - 4;
        ok = (k < 4) ? (t < nat_cnt(d)) : (t < bor_max(c) - nat_cnt(nbr(c, 1)));
        if (cell_borrow_i[c][k] && ok && !cell_keep_i[d][t]) begin
          sum[c] = sum[c] | gpt[nat_base(d) + t];
        end
      end
      sum[c] = sum[c] ^ cell_invert_i[c];
      cell_out[c] = cell_comb_i[c] ? sum[c] : ff_r[c];
    end
  end

  // ==========================================================
  // cell flip-flops
  always_comb begin
    for (int c = 0; c < N_CELL; c++) begin
      logic src;
      logic edg;
      logic ld;
      logic aux;
      src = cell_common_clk_i[c] ? in_pd_i[0] : gpt[GPT_CLK + c];
      edg = src & ~clk_prev_r[c];
      clk_prev_nxt[c] = src;
      ld = (c < 8) ? load_ab_i & ~mask_ab_i[c] : load_bc_i & ~mask_bc_i[c - 8];
      aux = gpt[GPT_AUX + c];
      ff_nxt[c] = ff_r[c];
      if (ld) begin
        ff_nxt[c] = load_data_i[c & 7];
      end else if (gpt[GPT_PR + c]) begin
        ff_nxt[c] = 1'b1;
      end else if (gpt[GPT_CLR + c]) begin
        ff_nxt[c] = 1'b0;
      end else if (edg) begin
        unique case (cell_type_i[c])
          PLDC_FF_D:  ff_nxt[c] = sum[c];
          PLDC_FF_T:  ff_nxt[c] = ff_r[c] ^ sum[c];
          PLDC_FF_JK: ff_nxt[c] = (sum[c] & ~ff_r[c]) | (~aux & ff_r[c]);
          PLDC_FF_SR: ff_nxt[c] = sum[c] | (~aux & ff_r[c]);
        endcase
      end
    end
    fb_nxt = cell_out;
    rab_nxt = cell_out[7:0];
    rbc_nxt = cell_out[15:8];
  end

  // ==========================================================
  // output allocator
  always_comb begin
    pa_nxt = PIN_RST;
    pa_oen_nxt = OEN_RST;
    pb_nxt = PIN_RST;
    pb_oen_nxt = OEN_RST;
    pc_nxt = PIN_RST;
    pc_oen_nxt = OEN_RST;
    for (int j = 0; j < 8; j++) begin
      if (cell_route_i[j + 8] == PLDC_RT_FIRST) begin
        pb_nxt[j] = cell_out[j + 8];
        pb_oen_nxt[j] = 1'b0;
      end
      if (cell_route_i[j + 8] == PLDC_RT_SECOND && PORTC_PINS[j]) begin
        pc_nxt[j] = cell_out[j + 8];
        pc_oen_nxt[j] = 1'b0;
      end
      if (cell_route_i[j] == PLDC_RT_FIRST && large_pkg_i) begin
        pa_nxt[j] = cell_out[j];
        pa_oen_nxt[j] = 1'b0;
      end
      if (cell_route_i[j] == PLDC_RT_SECOND) begin
        pb_nxt[j] = cell_out[j];
        pb_oen_nxt[j] = 1'b0;
      end
    end
  end

  // ==========================================================
  // cell registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ff_r <= {N_CELL{CELL_RST}};
      clk_prev_r <= 16'h0000;
      fb_r <= {N_CELL{CELL_RST}};
      read_ab_o <= 8'h00;
      read_bc_o <= 8'h00;
    end else if (ce_i) begin
      ff_r <= ff_nxt;
      clk_prev_r <= clk_prev_nxt;
      fb_r <= fb_nxt;
      read_ab_o <= rab_nxt;
      read_bc_o <= rbc_nxt;
    end
  end

  // ==========================================================
  // decode registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int k = 0; k < EXP_CYC; k++) begin
        exp_r[k] <= 9'h000;
      end
      main_flash_sector_selects_o <= 8'h00;
      secondary_flash_sector_selects_o <= 4'h0;
      sram_select_o <= 1'b0;
      reg_window_select_o <= 1'b0;
      ext_cs_o <= 2'h0;
      peripheral_port_select_lo_o <= 1'b0;
      peripheral_port_select_hi_o <= 1'b0;
    end else if (ce_i) begin
      exp_r <= exp_nxt;
      main_flash_sector_selects_o <= mfs_nxt;
      secondary_flash_sector_selects_o <= sfs_nxt;
      sram_select_o <= sram_nxt;
      reg_window_select_o <= regw_nxt;
      ext_cs_o <= ecs_nxt;
      peripheral_port_select_lo_o <= psl_nxt;
      peripheral_port_select_hi_o <= psh_nxt;
    end
  end

  // ==========================================================
  // pin registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      port_a_o <= PIN_RST;
      port_a_oe_n_o <= OEN_RST;
      port_b_o <= PIN_RST;
      port_b_oe_n_o <= OEN_RST;
      port_c_o <= PIN_RST;
      port_c_oe_n_o <= OEN_RST;
    end else if (ce_i) begin
      port_a_o <= pa_nxt;
      port_a_oe_n_o <= pa_oen_nxt;
      port_b_o <= pb_nxt;
      port_b_oe_n_o <= pb_oen_nxt;
      port_c_o <= pc_nxt;
      port_c_oe_n_o <= pc_oen_nxt;
    end
  end
  // configuration ports are sampled every cycle and must stay fixed
endmodule
`default_nettype wire

// [verification/pldc_pins.sv]
/*
  pin model for ports a, b and c of pldc_top.
  assumes a pull-up on every port pin.
*/
`default_nettype none
module pldc_pins (
  input  wire logic [7:0] port_a_o,
  input  wire logic [7:0] port_a_oe_n_o,
  input  wire logic [7:0] port_b_o,
  input  wire logic [7:0] port_b_oe_n_o,
  input  wire logic [7:0] port_c_o,
  input  wire logic [7:0] port_c_oe_n_o,
  output logic      [7:0] pin_a,
  output logic      [7:0] pin_b,
  output logic      [7:0] pin_c
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // undriven pins float high
  assign pin_a = port_a_oe_n_o | port_a_o;
  assign pin_b = port_b_oe_n_o | port_b_o;
  assign pin_c = port_c_oe_n_o | port_c_o;
endmodule
`default_nettype wire

// [verification/pldc_assertions.sv]
/*
  assertions on decode selects and pin routing of pldc_top.
  assumes static configuration inputs.
*/
`default_nettype none
module pldc_chk (
  input wire logic                      mclk_i,
  input wire logic                      rst_i,
  input wire logic                      ce_i,
  input wire logic [15:0]               addr_i,
  input wire logic [3:0]                bus_ctl_i,
  input wire logic                      mcu_reset_i,
  input wire logic                      power_down_i,
  input wire logic [7:0]                in_pa_i,
  input wire logic [7:0]                in_pb_i,
  input wire logic [3:0]                in_pc_i,
  input wire logic [1:0]                in_pd_i,
  input wire logic [7:0]                page_i,
  input wire logic                      flash_ready_i,
  input wire logic                      large_pkg_i,
  input wire logic [42:0][68:0]         dec_true_i,
  input wire logic [42:0][68:0]         dec_comp_i,
  input wire logic [8:0]                dec_exp_en_i,
  input wire pldc_pkg::pldc_route_e [15:0] cell_route_i,
  input wire logic [7:0]                main_flash_sector_selects_o,
  input wire logic [3:0]                secondary_flash_sector_selects_o,
  input wire logic                      sram_select_o,
  input wire logic                      reg_window_select_o,
  input wire logic [1:0]                ext_cs_o,
  input wire logic                      peripheral_port_select_lo_o,
  input wire logic                      peripheral_port_select_hi_o,
  input wire logic [7:0]                port_a_oe_n_o,
  input wire logic [7:0]                port_b_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import pldc_pkg::*;
  // ==========================================================
  // term values, feedback-free decode only
  logic [68:0] bus;
  logic [42:0] t;
  logic [7:0]  m_or;
  logic [3:0]  s_or;
  logic        nfb;
  assign bus = {flash_ready_i, 16'h0000, page_i, in_pd_i, in_pc_i, in_pb_i, in_pa_i,
                power_down_i, mcu_reset_i, bus_ctl_i, addr_i};
  always_comb begin
    nfb = 1'h1;
    for (int i = 0; i < N_DPT; i++) begin
      t[i] = (bus & dec_true_i[i]) == dec_true_i[i] && (bus & dec_comp_i[i]) == '0
             && (dec_true_i[i] | dec_comp_i[i]) != '0;
      if ((dec_true_i[i][67:52] | dec_comp_i[i][67:52]) != '0) nfb = 1'h0;
    end
    for (int s = 0; s < 8; s++) m_or[s] = |t[3 * s +: 3];
    for (int s = 0; s < 4; s++) s_or[s] = |t[24 + 3 * s +: 3];
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // assertions
  a_main_or: assert property (ce_i && nfb |=>
    ((main_flash_sector_selects_o ^ $past(m_or)) & ~$past(dec_exp_en_i[7:0])) == '0)
    else $error("main select differs from its terms");
  a_sec_or: assert property (ce_i && nfb |=>
    secondary_flash_sector_selects_o == $past(s_or)) else $error("secondary select wrong");
  a_sram_or: assert property (ce_i && nfb && !dec_exp_en_i[8] |=>
    sram_select_o == $past(t[36] | t[37])) else $error("sram select wrong");
  a_reg_win: assert property (ce_i && nfb && t[38] |-> ##1 reg_window_select_o)
    else $error("register window select missing");
  a_ext_cs: assert property (ce_i && nfb |=>
    ext_cs_o == $past({large_pkg_i & t[40], t[39]})) else $error("external select wrong");
  a_psel_pair: assert property (ce_i && nfb |=>
    {peripheral_port_select_hi_o, peripheral_port_select_lo_o} ==
    $past({2{large_pkg_i}} & t[42:41])) else $error("peripheral select wrong");
  a_small_pkg: assert property ((ce_i && !large_pkg_i) [*2] |->
    port_a_oe_n_o == 8'hff) else $error("port a driven on small package");
  a_one_pin: assert property (ce_i && large_pkg_i && cell_route_i[0] == PLDC_RT_FIRST
    && cell_route_i[8] != PLDC_RT_FIRST |=> !port_a_oe_n_o[0] && port_b_oe_n_o[0])
    else $error("cell drives other than one pin");
endmodule
bind pldc_top pldc_chk pldc_chk_i (.*);
`default_nettype wire

// [verification/tb.sv]
/*
  bench for pldc_top: random traffic in eight configuration phases against a model.
  assumes pldc_pkg, pldc_pins and pldc_chk are compiled first.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pldc_pkg::*;
  // ==========================================================
  // signals and model state
  logic               mclk_i = '0, rst_i = '1, ce_i = '1, mcu_reset_i = '0;
  logic               power_down_i = '0, flash_ready_i = '0, large_pkg_i = '1;
  logic               load_ab_i = '0, load_bc_i = '0, src_p, o_last;
  logic [34:0]        hold;
  logic [15:0]        addr_i = '0;
  logic [3:0]         bus_ctl_i = '0, in_pc_i = '0, secondary_flash_sector_selects_o;
  logic [1:0]         in_pd_i = '0, ext_cs_o;
  logic [7:0]         in_pa_i = '0, in_pb_i = '0, page_i = '0, load_data_i = '0;
  logic [7:0]         mask_ab_i = '0, mask_bc_i = '0, ffa, ffb, pin_a, pin_b, pin_c;
  logic [42:0][68:0]  dec_true_i = '0, dec_comp_i = '0;
  logic [8:0]         dec_exp_en_i = '0;
  logic [8:0][3:0]    dec_exp_cell_i = '0;
  logic [119:0][68:0] gen_true_i = '0, gen_comp_i = '0;
  logic [15:0][3:0]   cell_keep_i = '0;
  logic [15:0][7:0]   cell_borrow_i = '0;
  logic [15:0]        cell_invert_i = '0, cell_comb_i = '0, cell_common_clk_i = '0;
  pldc_ff_e [15:0]    cell_type_i;
  pldc_route_e [15:0] cell_route_i;
  logic [7:0]         main_flash_sector_selects_o, read_ab_o, read_bc_o, port_a_o;
  logic [7:0]         port_a_oe_n_o, port_b_o, port_b_oe_n_o, port_c_o, port_c_oe_n_o;
  logic               sram_select_o, reg_window_select_o;
  logic               peripheral_port_select_lo_o, peripheral_port_select_hi_o;
  logic [68:0]        bus;
  int                 mismatches = 0, n_compared = 0, cyc = 0;
  pldc_top  pldc_top_i  (.*);
  pldc_pins pldc_pins_i (.*);
  // ==========================================================
  // helpers
  function automatic logic pt(logic [68:0] tr, logic [68:0] cm);
    return (bus & tr) == tr && (bus & cm) == '0 && (tr | cm) != '0;
  endfunction
  function automatic logic d(int t);
    return pt(dec_true_i[t], dec_comp_i[t]);
  endfunction
  function automatic logic g(int t);
    return pt(gen_true_i[t], gen_comp_i[t]);
  endfunction
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // reset with a new static configuration
  task automatic restart(int ph);
    @(posedge mclk_i);
    rst_i <= '1;
    ce_i <= '1;
    cell_type_i[0] <= pldc_ff_e'(ph[1:0]);
    cell_common_clk_i[0] <= ph[2];
    cell_comb_i[0] <= ph == 5;
    cell_invert_i[0] <= ph[0];
    large_pkg_i <= ph != 6;
    repeat (3) @(posedge mclk_i);
    #1;
    chk("reset", {main_flash_sector_selects_o, read_ab_o, read_bc_o, port_a_oe_n_o,
        port_b_oe_n_o, port_a_o}, {24'h0, OEN_RST, OEN_RST, PIN_RST});
    @(posedge mclk_i);
    rst_i <= '0;
    ffa = '0;
    ffb = '0;
    src_p = '0;
    o_last = '0;
  endtask
  // ==========================================================
  // one edge: model, new inputs, compare
  task automatic tick();
    logic [17:0] e, v;
    logic [31:0] r, u;
    logic [7:0]  pa, pb;
    logic        s, k, src, q, o;
    bus = {flash_ready_i, 16'h0000, page_i, in_pd_i, in_pc_i, in_pb_i, in_pa_i,
           power_down_i, mcu_reset_i, bus_ctl_i, addr_i};
    for (int i = 0; i < 8; i++) e[i] = d(3 * i) | d(3 * i + 1) | d(3 * i + 2);
    for (int i = 0; i < 4; i++) e[8 + i] = d(24 + 3 * i) | d(25 + 3 * i) | d(26 + 3 * i);
    e[17:12] = {large_pkg_i & d(42), large_pkg_i & d(41), large_pkg_i & d(40), d(39),
                d(38), d(36) | d(37)};
    e[7] = e[7] | o_last;
    s = g(0) ^ cell_invert_i[0];
    k = g(GPT_AUX);
    src = cell_common_clk_i[0] ? in_pd_i[0] : g(GPT_CLK);
    q = ffa[0];
    o = cell_comb_i[0] ? s : q;
    if (src && !src_p) begin
      case (cell_type_i[0])
        PLDC_FF_D:  q = s;
        PLDC_FF_T:  q = q ^ s;
        PLDC_FF_JK: q = (s & ~q) | (~k & q);
        default:    q = s | (q & ~k);
      endcase
    end
    if (g(GPT_CLR)) q = '0;
    if (g(GPT_PR)) q = '1;
    pa = {ffa[7:1], o};
    pb = ffb;
    if (ce_i) begin
      src_p = src;
      ffa[0] = q;
      if (load_ab_i) ffa = (ffa & mask_ab_i) | (load_data_i & ~mask_ab_i);
      if (load_bc_i) ffb = (ffb & mask_bc_i) | (load_data_i & ~mask_bc_i);
      hold = {e, pa, pb, o};
    end
    {e, pa, pb, o} = hold;
    o_last = o;
    r = $urandom;
    u = $urandom;
    @(posedge mclk_i);
    addr_i <= r[15:0];
    page_i <= r[23:16];
    in_pd_i <= r[25:24];
    load_ab_i <= r[27:26] == 2'h0;
    load_bc_i <= r[29:28] == 2'h0;
    load_data_i <= u[7:0];
    mask_ab_i <= u[15:8] & {8{r[30]}};
    mask_bc_i <= u[23:16];
    ce_i <= r[31] | u[31];
    #1;
    v = {peripheral_port_select_hi_o, peripheral_port_select_lo_o, ext_cs_o,
         reg_window_select_o, sram_select_o, secondary_flash_sector_selects_o,
         main_flash_sector_selects_o};
    chk("selects", v, e);
    chk("read_ab", read_ab_o, pa);
    chk("read_bc", read_bc_o, pb);
    chk("pins", {port_a_oe_n_o, port_b_oe_n_o, port_c_oe_n_o, port_a_o[0],
        pin_a[0]}, {large_pkg_i ? 8'hfe : 8'hff, 8'hfd, 8'hfb, o & large_pkg_i,
        o | ~large_pkg_i});
    chk("pins_bc", {port_b_o, port_c_o, pin_b[1], pin_c[2]},
        {6'h00, pb[1], 1'b0, 5'h00, pb[2], 2'h0, pb[1], pb[2]});
  endtask
  // ==========================================================
  // clock, timeout and main sequence
  initial forever #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    for (int i = 0; i < 16; i++) begin
      cell_type_i[i] = PLDC_FF_D;
      cell_route_i[i] = i == 0 ? PLDC_RT_FIRST : PLDC_RT_BURIED;
    end
    for (int t = 0; t < N_DPT; t++) begin
      dec_true_i[t][t % 16] = '1;
      if (t % 3 == 1) dec_comp_i[t][BUS_PAGE + t % 8] = '1;
    end
    gen_true_i[0][0] = '1;
    gen_true_i[GPT_CLK][4] = '1;
    gen_true_i[GPT_PR][1] = '1;
    gen_true_i[GPT_PR][3] = '1;
    gen_true_i[GPT_CLR][2] = '1;
    gen_true_i[GPT_CLR][3] = '1;
    gen_true_i[GPT_AUX][5] = '1;
    cell_keep_i[0] = 4'h1;
    cell_route_i[8] = PLDC_RT_SECOND;
    cell_route_i[9] = PLDC_RT_FIRST;
    cell_route_i[10] = PLDC_RT_SECOND;
    dec_exp_en_i[7] = '1;
    void'($urandom(42450));
    for (int ph = 0; ph < 8; ph++) begin
      restart(ph);
      repeat (150) tick();
    end
    close_out();
  end
endmodule
`default_nettype wire
